// ===== verilog/tpw_pkg.sv
// Shared constants and types for the timer PWM waveform unit
package tpw_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] TPW_CTRL_A_OFF = 8'h00;
    localparam logic [7:0] TPW_CTRL_B_OFF = 8'h04;
    localparam logic [7:0] TPW_COUNT_OFF = 8'h08;
    localparam logic [7:0] TPW_CMP_A_OFF = 8'h0c;
    localparam logic [7:0] TPW_CMP_B_OFF = 8'h10;
    localparam logic [7:0] TPW_FLAGS_OFF = 8'h14;
    // Field positions
    localparam int TPW_WAVE_HI_POS = 3;
    localparam int TPW_FLAG_OVF_POS = 0;
    localparam int TPW_FLAG_MA_POS = 1;
    localparam int TPW_FLAG_MB_POS = 2;
    // Reset values
    localparam logic [7:0] TPW_CTRL_A_RST = 8'h00;
    localparam logic [7:0] TPW_CTRL_B_RST = 8'h00;
    localparam logic [7:0] TPW_COUNT_RST = 8'h00;
    localparam logic [7:0] TPW_CMP_RST = 8'h00;
    localparam logic [2:0] TPW_FLAGS_RST = 3'h0;
    // Count extremes
    localparam logic [7:0] TPW_BOTTOM = 8'h00;
    localparam logic [7:0] TPW_MAX = 8'hff;
    // Prescaler masks: tick when the low prescaler bits are all ones
    localparam logic [9:0] TPW_DIV1_MASK = 10'h000;
    localparam logic [9:0] TPW_DIV8_MASK = 10'h007;
    localparam logic [9:0] TPW_DIV64_MASK = 10'h03f;
    localparam logic [9:0] TPW_DIV256_MASK = 10'h0ff;
    localparam logic [9:0] TPW_DIV1024_MASK = 10'h3ff;

    typedef enum logic [2:0] {
        TPW_WM_NORMAL = 3'b000,
        TPW_WM_PC_MAX = 3'b001,
        TPW_WM_CTC = 3'b010,
        TPW_WM_FAST_MAX = 3'b011,
        TPW_WM_RSV4 = 3'b100,
        TPW_WM_PC_CMP = 3'b101,
        TPW_WM_RSV6 = 3'b110,
        TPW_WM_FAST_CMP = 3'b111
    } tpw_wave_mode_e;

    typedef struct packed {
        logic [1:0] chan_a_output_mode;
        logic [1:0] chan_b_output_mode;
        logic [1:0] rsvd;
        logic [1:0] waveform_mode_low_bits;
    } tpw_ctrl_a_s;
endpackage

// ===== verilog/tpw_waveform_unit.sv
// Timer PWM waveform unit: counter, compare channels and APB registers
//
// How it works
// - Fast PWM counts bottom to TOP, restarts
// - Fixed-TOP fast PWM period is 256 ticks
// - Compare bottom spikes, compare MAX holds level
// - Fast PWM toggle mode halves match rate
// - Modes 1/5 count up then down
// - Counter holds TOP one tick, then reverses
// - Phase correct: clear up-match, set down-match
// - Phase correct overflow flag set at bottom
// - Fixed-TOP phase correct period is 510 ticks
// - Phase correct extremes give constant levels
// - Missed up-match transition still made
// - Nonzero output mode routes waveform to pin, except PWM mode 01 without toggle
// - Control A field layout, resets zero
// - Non-PWM: disconnect, toggle, clear, set
// - Fast PWM: match action, opposite at TOP
// - Mode 01 toggles only with high bit
// - Channel B never offers toggle in PWM
// - Phase correct mode 10/11 up/down actions
// - Compare equal TOP: action done at TOP
// - Tick is a clock enable only
// - Fast PWM overflow at TOP, then clear
`timescale 1ns/1ps
module tpw_waveform_unit
    import tpw_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Waveform pins and routing
    output logic chan_a_wave_out,
    output logic chan_b_wave_out,
    output logic chan_a_pin_sel_out,
    output logic chan_b_pin_sel_out,
    // Event flags
    output logic [2:0] flags_out
);

    function automatic logic [9:0] presc_mask(input logic [2:0] sel);
        case (sel)
            3'h1: presc_mask = TPW_DIV1_MASK;
            3'h2: presc_mask = TPW_DIV8_MASK;
            3'h3: presc_mask = TPW_DIV64_MASK;
            3'h4: presc_mask = TPW_DIV256_MASK;
            default: presc_mask = TPW_DIV1024_MASK;
        endcase
    endfunction

    // Next level of a compare output for one tick
    function automatic logic wave_next(input logic cur, input logic [1:0] mode,
        input logic tog_ok, input logic mtch, input logic top_evt, input logic up,
        input logic fast, input logic pc, input logic special, input logic miss_up);
        logic res;
        res = cur;
        if (fast || pc) begin
            if (mode == 2'b01) begin
                if (tog_ok && mtch) begin
                    res = ~cur;
                end
            end else if (mode[1]) begin
                if (fast) begin
                    if (mtch && !special) begin
                        res = mode[0];
                    end
                    if (top_evt) begin
                        res = ~mode[0];
                    end
                end else if (miss_up) begin
                    res = mode[0];
                end else if (special) begin
                    if (top_evt) begin
                        res = ~mode[0];
                    end
                end else if (mtch) begin
                    res = up ? mode[0] : ~mode[0];
                end
            end
        end else if (mtch) begin
            case (mode)
                2'b01: res = ~cur;
                2'b10: res = 1'b0;
                2'b11: res = 1'b1;
                default: res = cur;
            endcase
        end
        wave_next = res;
    endfunction

    tpw_ctrl_a_s ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] count_reg;
    logic [7:0] cmp_reg [2];
    logic [7:0] cmp_buf_reg [2];
    logic [2:0] flags_reg;
    logic [2:0] flags_next;
    logic [9:0] presc_reg;
    logic tick_reg;
    logic dir_up_reg;
    logic [1:0] seen_up_reg;
    logic [1:0] wave_reg;
    logic [1:0] pin_sel_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [2:0] wave_mode;
    logic fast_mode;
    logic pc_mode;
    logic pwm_mode;
    logic [7:0] top_val;
    logic at_top;
    logic bus_access;
    logic bus_write;
    logic addr_hit;
    logic [31:0] read_mux;
    logic [1:0] chan_mode [2];
    logic [1:0] match;
    logic [1:0] miss_up;
    logic [1:0] special;
    logic ovf_event;

    assign wave_mode = {ctrl_b_reg[TPW_WAVE_HI_POS], ctrl_a_reg.waveform_mode_low_bits};
    assign fast_mode = (wave_mode == TPW_WM_FAST_MAX) || (wave_mode == TPW_WM_FAST_CMP);
    assign pc_mode = (wave_mode == TPW_WM_PC_MAX) || (wave_mode == TPW_WM_PC_CMP);
    assign pwm_mode = fast_mode || pc_mode;
    // TOP from compare A in CTC and the high PWM modes; fixed MAX gives 256 or 510 ticks
    assign top_val = (wave_mode == TPW_WM_FAST_CMP || wave_mode == TPW_WM_PC_CMP ||
        wave_mode == TPW_WM_CTC) ? cmp_buf_reg[0] : TPW_MAX;
    assign at_top = (count_reg >= top_val);
    assign chan_mode[0] = ctrl_a_reg.chan_a_output_mode;
    assign chan_mode[1] = ctrl_a_reg.chan_b_output_mode;

    // APB: one wait state, access completes when pready is high
    assign bus_access = psel_in && penable_in;
    assign bus_write = bus_access && pready_reg && pwrite_in;

    always_comb begin
        addr_hit = 1'b1;
        read_mux = 32'h0000_0000;
        case (paddr_in)
            TPW_CTRL_A_OFF: read_mux = {24'h000000, ctrl_a_reg[7:4], 2'h0,
                ctrl_a_reg.waveform_mode_low_bits};
            TPW_CTRL_B_OFF: read_mux = {24'h000000, 4'h0, ctrl_b_reg[3:0]};
            TPW_COUNT_OFF: read_mux = {24'h000000, count_reg};
            TPW_CMP_A_OFF: read_mux = {24'h000000, cmp_reg[0]};
            TPW_CMP_B_OFF: read_mux = {24'h000000, cmp_reg[1]};
            TPW_FLAGS_OFF: read_mux = {29'h00000000, flags_reg};
            default: addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= bus_access && !pready_reg;
            pslverr_reg <= bus_access && !pready_reg && !addr_hit;
            if (bus_access && !pready_reg) begin
                prdata_reg <= pwrite_in ? 32'h0000_0000 : read_mux;
            end
        end
    end

    // Control registers; a new mode takes effect in the cycle after the write
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_a_reg <= TPW_CTRL_A_RST;
            ctrl_b_reg <= TPW_CTRL_B_RST;
        end else if (bus_write) begin
            if (paddr_in == TPW_CTRL_A_OFF) begin
                ctrl_a_reg <= {pwdata_in[7:4], 2'h0, pwdata_in[1:0]};
            end
            if (paddr_in == TPW_CTRL_B_OFF) begin
                ctrl_b_reg <= {4'h0, pwdata_in[3:0]};
            end
        end
    end

    // Prescaler: the tick is a one-cycle enable, never a clock
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_reg <= 10'h000;
            tick_reg <= 1'b0;
        end else begin
            presc_reg <= presc_reg + 10'h001;
            // Selects 0, 6 and 7 stop the timer; no external clock here
            tick_reg <= (ctrl_b_reg[2:0] != 3'h0) && (ctrl_b_reg[2:0] < 3'h6) &&
                ((presc_reg & presc_mask(ctrl_b_reg[2:0])) ==
                presc_mask(ctrl_b_reg[2:0]));
        end
    end

    // Counter and direction
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= TPW_COUNT_RST;
            dir_up_reg <= 1'b1;
        end else if (bus_write && paddr_in == TPW_COUNT_OFF) begin
            count_reg <= pwdata_in[7:0];
        end else if (tick_reg) begin
            if (pc_mode) begin
                if (dir_up_reg) begin
                    if (at_top && top_val != TPW_BOTTOM) begin
                        count_reg <= top_val - 8'h01;
                        dir_up_reg <= 1'b0;
                    end else if (!at_top) begin
                        count_reg <= count_reg + 8'h01;
                    end
                end else if (count_reg == TPW_BOTTOM) begin
                    count_reg <= count_reg + 8'h01;
                    dir_up_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg - 8'h01;
                end
            end else begin
                dir_up_reg <= 1'b1;
                count_reg <= at_top ? TPW_BOTTOM : count_reg + 8'h01;
            end
        end
    end

    assign ovf_event = tick_reg && (pc_mode ? (!dir_up_reg && count_reg == 8'h01) :
        (at_top && (fast_mode || count_reg == TPW_MAX)));
    // Sticky flags, write one to clear; a new event beats the clear
    always_comb begin
        flags_next = flags_reg;
        if (bus_write && paddr_in == TPW_FLAGS_OFF) begin
            flags_next = flags_reg & ~pwdata_in[2:0];
        end
        flags_next[TPW_FLAG_OVF_POS] = flags_next[TPW_FLAG_OVF_POS] | ovf_event;
        flags_next[TPW_FLAG_MA_POS] = flags_next[TPW_FLAG_MA_POS] | match[0];
        flags_next[TPW_FLAG_MB_POS] = flags_next[TPW_FLAG_MB_POS] | match[1];
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_reg <= TPW_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Compare channels: A at index 0, B at index 1
    for (genvar i = 0; i < 2; i++) begin : g_chan
        localparam logic [7:0] CMP_OFF = (i == 0) ? TPW_CMP_A_OFF : TPW_CMP_B_OFF;
        // Toggle in PWM exists only on channel A, with the high mode bit set
        localparam logic IS_A = (i == 0);
        assign match[i] = tick_reg && (count_reg == cmp_buf_reg[i]);
        assign special[i] = (cmp_buf_reg[i] == top_val) && chan_mode[i][1];
        assign miss_up[i] = tick_reg && pc_mode && dir_up_reg && at_top && ((!seen_up_reg[i] &&
            !match[i]) || (cmp_buf_reg[i] == TPW_MAX && cmp_reg[i] != TPW_MAX));

        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                cmp_reg[i] <= TPW_CMP_RST;
            end else if (bus_write && paddr_in == CMP_OFF) begin
                cmp_reg[i] <= pwdata_in[7:0];
            end
        end

        // Double buffered in PWM, loaded at TOP; direct otherwise
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                cmp_buf_reg[i] <= TPW_CMP_RST;
            end else if (!pwm_mode || (tick_reg && at_top)) begin
                cmp_buf_reg[i] <= cmp_reg[i];
            end
        end

        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                seen_up_reg[i] <= 1'b0;
            end else if (bus_write && paddr_in == TPW_COUNT_OFF) begin
                seen_up_reg[i] <= 1'b0;
            end else if (tick_reg && count_reg == TPW_BOTTOM) begin
                seen_up_reg[i] <= match[i];
            end else if (match[i] && dir_up_reg) begin
                seen_up_reg[i] <= 1'b1;
            end
        end

        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                wave_reg[i] <= 1'b0;
            end else if (tick_reg) begin
                wave_reg[i] <= wave_next(wave_reg[i], chan_mode[i],
                    IS_A && ctrl_b_reg[TPW_WAVE_HI_POS], match[i], at_top,
                    dir_up_reg || count_reg == TPW_BOTTOM, fast_mode, pc_mode,
                    special[i], miss_up[i]);
            end
        end

        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                pin_sel_reg[i] <= 1'b0;
            end else begin
                pin_sel_reg[i] <= (chan_mode[i] != 2'b00) && !(pwm_mode &&
                    chan_mode[i] == 2'b01 && !(IS_A && ctrl_b_reg[TPW_WAVE_HI_POS]));
            end
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign chan_a_wave_out = wave_reg[0];
    assign chan_b_wave_out = wave_reg[1];
    assign chan_a_pin_sel_out = pin_sel_reg[0];
    assign chan_b_pin_sel_out = pin_sel_reg[1];
    assign flags_out = flags_reg;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    a_fast_wrap_top: assert property (
        fast_mode && tick_reg && count_reg == top_val && !bus_write |=> count_reg == TPW_BOTTOM)
        else $error("fast pwm counter did not clear after top");
    a_fast_ovf_flag: assert property (
        fast_mode && tick_reg && count_reg == top_val |=> flags_reg[TPW_FLAG_OVF_POS])
        else $error("fast pwm overflow flag not set at top");
    a_pc_top_turn: assert property (
        pc_mode && tick_reg && dir_up_reg && count_reg == top_val && top_val != 8'h00
        && !bus_write |=> !dir_up_reg && count_reg == $past(top_val) - 8'h01)
        else $error("phase correct counter did not turn at top");
    a_pc_bottom_ovf: assert property (
        pc_mode && tick_reg && !dir_up_reg && count_reg == 8'h01 && !bus_write
        |=> count_reg == TPW_BOTTOM && flags_reg[TPW_FLAG_OVF_POS])
        else $error("phase correct overflow not flagged at bottom");
    a_fixed_top_max: assert property (
        wave_mode == TPW_WM_FAST_MAX || wave_mode == TPW_WM_PC_MAX |-> top_val == 8'hff)
        else $error("fixed top is not max");
    a_fast_top_set: assert property (
        fast_mode && tick_reg && count_reg == top_val && chan_mode[0] == 2'b10 |=> chan_a_wave_out)
        else $error("fast pwm output not set at top");
    a_pc_up_clear: assert property (
        pc_mode && match[0] && dir_up_reg && chan_mode[0] == 2'b10 && !special[0]
        |=> !chan_a_wave_out)
        else $error("phase correct up match did not clear");
    a_pin_release: assert property (
        chan_mode[0] == 2'b00 |=> !chan_a_pin_sel_out)
        else $error("pin kept while output mode is zero");
    a_b_no_toggle: assert property (
        pwm_mode && chan_mode[1] == 2'b01 |=> !chan_b_pin_sel_out)
        else $error("channel b toggle offered in pwm");
    a_count_gated: assert property (
        !tick_reg && !bus_write |=> $stable(count_reg))
        else $error("counter moved without a tick");
    a_rsvd_zero: assert property (
        pready_reg && !pwrite_in && paddr_in == TPW_CTRL_A_OFF |-> prdata_reg[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");

    c_fast_wrap: cover property (fast_mode && tick_reg && count_reg == top_val);
    c_pc_turn: cover property (pc_mode && tick_reg && dir_up_reg && count_reg == top_val);
    c_pc_missed: cover property (miss_up[0]);
    c_toggle: cover property (pwm_mode && chan_mode[0] == 2'b01 && match[0]);

endmodule

// ===== verif/tpw_pin_model.sv
// Pad driver and port direction model on the far side of the waveform unit
`timescale 1ns/1ps
module tpw_pin_model (
    // Routing and waveform from the unit
    input wire logic pin_sel_in,
    input wire logic wave_in,
    // Port side
    input wire logic dir_out_en_in,
    input wire logic port_data_in,
    // Pad
    output logic pin_out
);
    // Driver stays off unless the direction bit says output; the pad pull-up then wins
    assign pin_out = dir_out_en_in ? (pin_sel_in ? wave_in : port_data_in) : 1'b1;
endmodule

// ===== verif/test_tpw_waveform_unit.sv
// Self-checking testbench for the timer PWM waveform unit
`timescale 1ns/1ps
module test_tpw_waveform_unit;
    import tpw_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wave_a;
    logic wave_b;
    logic sel_a;
    logic sel_b;
    logic [2:0] flags;
    logic dir_en = 1'b1;
    logic port_data = 1'b0;
    logic pin;
    logic [31:0] rd;
    logic last_err;
    int miscompares = 0;
    int compares = 0;
    int hi_cnt;
    int tog_cnt;
    int hib_cnt;

    always #20 clock_in = ~clock_in;

    tpw_waveform_unit uut (
        .clock_in(clock_in), .rst_n_in(rst_n_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .chan_a_wave_out(wave_a), .chan_b_wave_out(wave_b),
        .chan_a_pin_sel_out(sel_a), .chan_b_pin_sel_out(sel_b), .flags_out(flags)
    );

    tpw_pin_model pad (
        .pin_sel_in(sel_a), .wave_in(wave_a), .dir_out_en_in(dir_en),
        .port_data_in(port_data), .pin_out(pin)
    );

    task wrap_up();
        $display("counts: %0d compares, %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the bus idles one cycle after it so no signal is set twice per step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            wrap_up();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_in);
    endtask

    // Compare value is loaded while stopped in normal mode, where the shadow copy is bypassed
    task setup(input logic [3:0] com, input logic [2:0] wm, input logic [2:0] cs,
               input logic [7:0] cmp, input logic [7:0] cnt);
        // A few idle ticks in normal mode leave the count direction up; outputs stay put
        apb(1'b1, TPW_CTRL_A_OFF, 32'h0);
        apb(1'b1, TPW_CTRL_B_OFF, 32'h1);
        apb(1'b1, TPW_CTRL_B_OFF, 32'h0);
        apb(1'b1, TPW_CMP_A_OFF, {24'h0, cmp});
        apb(1'b1, TPW_COUNT_OFF, {24'h0, cnt});
        apb(1'b1, TPW_FLAGS_OFF, 32'h7);
        apb(1'b1, TPW_CTRL_A_OFF, {24'h0, com, 2'b00, wm[1:0]});
        apb(1'b1, TPW_CTRL_B_OFF, {28'h0, wm[2], cs});
    endtask

    // Window of n samples after settling; a whole number of periods, so phase does not matter
    task meas(input int n);
        logic prev;
        hi_cnt = 0;
        tog_cnt = 0;
        hib_cnt = 0;
        repeat (n + 600) @(posedge clock_in);
        prev = wave_a;
        for (int i = 0; i < n; i++) begin
            @(posedge clock_in);
            if (wave_a === 1'b1) hi_cnt++;
            if (wave_b === 1'b1) hib_cnt++;
            if (wave_a !== prev) tog_cnt++;
            prev = wave_a;
        end
    endtask

    initial begin
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        apb(1'b0, TPW_CTRL_A_OFF, 32'h0);
        check_val("ctrl_a reset", {24'h0, TPW_CTRL_A_RST}, rd);
        check_val("flags reset", 32'h0, {29'h0, flags});
        check_val("sel_a reset", 32'h0, {31'h0, sel_a});
        apb(1'b1, TPW_CTRL_A_OFF, 32'hff);
        apb(1'b0, TPW_CTRL_A_OFF, 32'h0);
        check_val("ctrl_a readback", 32'hf3, rd);
        apb(1'b0, 8'h18, 32'h0);
        check_val("unmapped data", 32'h0, rd);
        check_val("unmapped err", 32'h1, {31'h0, last_err});
        $display("test registers done");

        setup(4'b1010, 3'd3, 3'd1, 8'h40, 8'h00);
        apb(1'b1, TPW_CMP_B_OFF, 32'h80);
        meas(256);
        check_val("fast clear duty", 32'd65, 32'(hi_cnt));
        check_val("fast b clear duty", 32'd129, 32'(hib_cnt));
        check_val("fast edges", 32'd2, 32'(tog_cnt));
        check_val("sel_a fast", 32'h1, {31'h0, sel_a});
        setup(4'b1100, 3'd3, 3'd1, 8'h40, 8'h00);
        meas(256);
        check_val("fast set duty", 32'd191, 32'(hi_cnt));
        setup(4'b1000, 3'd3, 3'd1, 8'hff, 8'h00);
        meas(256);
        check_val("fast max", 32'd256, 32'(hi_cnt));
        setup(4'b1000, 3'd3, 3'd1, 8'h00, 8'h00);
        meas(256);
        check_val("fast spike", 32'd1, 32'(hi_cnt));
        setup(4'b1000, 3'd3, 3'd2, 8'h40, 8'h00);
        meas(2048);
        check_val("fast div8 duty", 32'd520, 32'(hi_cnt));
        check_val("fast div8 edges", 32'd2, 32'(tog_cnt));
        $display("test fast pwm done");

        setup(4'b1000, 3'd1, 3'd1, 8'h40, 8'h00);
        meas(510);
        check_val("pc clear duty", 32'd128, 32'(hi_cnt));
        check_val("pc edges", 32'd2, 32'(tog_cnt));
        apb(1'b0, TPW_FLAGS_OFF, 32'h0);
        check_val("pc overflow", 32'h1, rd & 32'h1);
        setup(4'b1100, 3'd1, 3'd1, 8'h40, 8'h00);
        meas(510);
        check_val("pc set duty", 32'd382, 32'(hi_cnt));
        setup(4'b1000, 3'd1, 3'd1, 8'h00, 8'h00);
        meas(510);
        check_val("pc bottom", 32'd0, 32'(hi_cnt));
        check_val("pin driven", 32'h0, {31'h0, pin});
        dir_en <= 1'b0;
        @(posedge clock_in);
        check_val("pin released", 32'h1, {31'h0, pin});
        dir_en <= 1'b1;
        setup(4'b1000, 3'd1, 3'd1, 8'hff, 8'h00);
        meas(510);
        check_val("pc max", 32'd510, 32'(hi_cnt));
        // Output is high here; starting above the compare value must still clear it at TOP
        setup(4'b1000, 3'd1, 3'd1, 8'h40, 8'h80);
        repeat (150) @(posedge clock_in);
        check_val("pc missed match", 32'h0, {31'h0, wave_a});
        $display("test phase correct done");

        setup(4'b0100, 3'd7, 3'd1, 8'h00, 8'h00);
        meas(20);
        check_val("toggle edges", 32'd20, 32'(tog_cnt));
        check_val("toggle duty", 32'd10, 32'(hi_cnt));
        check_val("sel_a toggle", 32'h1, {31'h0, sel_a});
        setup(4'b0100, 3'd3, 3'd1, 8'h00, 8'h00);
        check_val("sel_a no toggle", 32'h0, {31'h0, sel_a});
        port_data <= 1'b1;
        @(posedge clock_in);
        check_val("pin from port", 32'h1, {31'h0, pin});
        port_data <= 1'b0;
        setup(4'b0001, 3'd7, 3'd1, 8'h10, 8'h00);
        check_val("sel_b no toggle", 32'h0, {31'h0, sel_b});
        setup(4'b0010, 3'd3, 3'd1, 8'h10, 8'h00);
        check_val("sel_b pwm", 32'h1, {31'h0, sel_b});
        $display("test output modes done");

        setup(4'b0100, 3'd0, 3'd1, 8'h40, 8'h00);
        meas(512);
        check_val("normal toggle edges", 32'd2, 32'(tog_cnt));
        check_val("normal toggle duty", 32'd256, 32'(hi_cnt));
        setup(4'b1100, 3'd0, 3'd1, 8'h40, 8'h00);
        meas(256);
        check_val("normal set", 32'd256, 32'(hi_cnt));
        setup(4'b1000, 3'd0, 3'd1, 8'h40, 8'h00);
        meas(256);
        check_val("normal clear", 32'd0, 32'(hi_cnt));
        $display("test non-pwm done");
        wrap_up();
    end
endmodule
